// [hw/ifp_frame_mem.sv]
// small memory holding the eight sixteen-bit words of the trap frame
// assumes the main block writes one word per cycle and reads one word back
`timescale 1ns/1ps
module ifp_frame_mem
	import ifp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic wr_en,
	input wire logic [2:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [2:0] rd_addr,
	output logic [15:0] rd_data
);
	logic [15:0] mem [IFP_FRAME_WORDS]; // frame storage

	// write port, no reset needed on storage
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// registered read port
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rd_data <= 16'h0000;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : ifp_frame_mem

// [hw/ifp_pkg.sv]
// package of constants for the integer-only float trap and reset configuration block
// assumes one clock domain and a synchronous active-low reset
package ifp_pkg;
	localparam logic [3:0] IFP_FRAME_FORMAT = 4'h4; // format code of the eight-word trap frame
	localparam logic [7:0] IFP_VECTOR_NUM = 8'h0b; // vector number 11 for the float trap
	localparam logic [11:0] IFP_VECTOR_OFFSET = {2'h0, IFP_VECTOR_NUM, 2'h0}; // vector number times four
	localparam int IFP_FRAME_WORDS = 8; // sixteen-bit words in the frame
	localparam logic [2:0] IFP_FRAME_LAST = 3'h7; // index of the last frame word
	localparam logic [31:0] IFP_EA_NONE = 32'h0000_0000; // address field for immediate or register modes
	localparam int IFP_SR_T1 = 15; // trace bit high position in the status word
	localparam int IFP_SR_T0 = 14; // trace bit low position
	localparam int IFP_SR_S = 13; // supervisor bit position
	localparam logic [15:0] IFP_SR_RESET = 16'h2700; // status word after reset
	localparam logic [1:0] IFP_BUS_MODE_SYNC = 2'h0; // ordinary non-multiplexed synchronous bus
	localparam logic IFP_IMPEDANCE_SMALL = 1'b1; // small output impedance setting
	typedef enum logic [2:0] {IFP_IDLE, IFP_DRAIN, IFP_ENTER, IFP_PUSH, IFP_VECTOR, IFP_REFILL} ifp_state_e;
endpackage : ifp_pkg

// [hw/ifp_trap_unit.sv]
// trap sequencer for float instructions on the integer-only part, plus fixed reset configuration
// What this block does
// - every float instruction traps, never executes
// - push eight-word frame with format four
// - frame holds status, pc, offset, address, fault pc
// - no latch or multiplexed bus modes
// - cache disable pin ignored at reset
// - impedance fixed small, priority pins ignored
// - former latch pin only selects scan chain
// - wait for earlier instructions and write-backs
// - copy status, enter supervisor, clear trace bits
// - address field zero for immediate/register modes
// - use vector eleven, fetch handler, refill
// assumes the pipeline presents a decoded float instruction as a level until trap_taken
`timescale 1ns/1ps
module ifp_trap_unit
	import ifp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic fp_instr_valid, // decoder saw a float opcode
	input wire logic [31:0] fp_instr_pc, // address of the float instruction
	input wire logic [31:0] next_pc_in, // address of the following instruction
	input wire logic [31:0] fp_ea, // calculated operand address
	input wire logic fp_ea_none, // immediate or register direct mode
	input wire logic pipe_idle, // earlier instructions, write-backs, exceptions done
	input wire logic [15:0] status_word_in, // current status word
	input wire logic [31:0] vbr, // vector table base
	input wire logic [31:0] stack_ptr, // supervisor stack pointer
	input wire logic mem_ready, // memory accepted the current access
	input wire logic [31:0] mem_rdata, // read data for the vector fetch
	input wire logic refill_done, // pipeline prefetch complete
	input wire logic cache_disable_pin, // unused, ignored
	input wire logic [2:0] interrupt_priority_pins, // not a configuration input here
	input wire logic scan_select_pin, // former data latch enable
	output logic fp_exec_enable, // float execution, always off
	output logic trap_taken, // one-cycle pulse when the handler starts
	output logic [15:0] status_word_out, // status word after entry
	output logic status_word_we, // pulse writing status_word_out
	output logic mem_wr, // stack write strobe
	output logic mem_rd, // vector read strobe
	output logic [31:0] mem_addr, // access address
	output logic [15:0] mem_wdata, // stack write data
	output logic [31:0] handler_pc, // fetched handler address
	output logic refill_req, // ask pipeline to refill
	output logic [31:0] new_sp, // stack pointer after the push
	output logic [1:0] bus_mode, // bus operating mode
	output logic impedance_small, // output buffer impedance setting
	output logic scan_chain_sel // scan chain selection
);
	ifp_state_e state; // sequencer state
	logic [15:0] saved_sr; // internal copy of the status word
	logic [31:0] saved_pc; // return address
	logic [31:0] saved_ea; // operand address
	logic [31:0] saved_fpc; // faulted instruction address
	logic [2:0] word_idx; // frame word being written
	logic [15:0] frame_word; // frame word for word_idx
	logic [2:0] rd_idx; // readback index
	logic [15:0] frame_rd; // readback word, for debug inspection

	// fixed configuration: nothing sampled at reset can change the bus mode
	// cache_disable_pin and interrupt_priority_pins are deliberately unused
	assign bus_mode = IFP_BUS_MODE_SYNC;
	assign impedance_small = IFP_IMPEDANCE_SMALL;
	assign scan_chain_sel = scan_select_pin;
	assign fp_exec_enable = 1'b0;

	// frame layout, word 0 at the new stack pointer, sixteen bytes below stack_ptr
	always_comb begin
		case (word_idx)
			3'h0: frame_word = saved_sr;
			3'h1: frame_word = saved_pc[31:16];
			3'h2: frame_word = saved_pc[15:0];
			3'h3: frame_word = {IFP_FRAME_FORMAT, IFP_VECTOR_OFFSET};
			3'h4: frame_word = saved_ea[31:16];
			3'h5: frame_word = saved_ea[15:0];
			3'h6: frame_word = saved_fpc[31:16];
			3'h7: frame_word = saved_fpc[15:0];
			default: frame_word = 16'h0000;
		endcase
	end

	// frame copy kept for inspection; the read is registered in the memory
	ifp_frame_mem u_mem (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.wr_en(state == IFP_PUSH && mem_ready),
		.wr_addr(word_idx),
		.wr_data(frame_word),
		.rd_addr(rd_idx),
		.rd_data(frame_rd)
	);

	// sequencer: drain, enter, push eight words, fetch vector, refill
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state <= IFP_IDLE;
			word_idx <= 3'h0;
		end else begin
			case (state)
				IFP_IDLE: if (fp_instr_valid) state <= IFP_DRAIN;
				IFP_DRAIN: if (pipe_idle) state <= IFP_ENTER;
				IFP_ENTER: begin
					state <= IFP_PUSH;
					word_idx <= 3'h0;
				end
				IFP_PUSH: if (mem_ready) begin
					if (word_idx == IFP_FRAME_LAST) state <= IFP_VECTOR;
					else word_idx <= word_idx + 3'h1;
				end
				IFP_VECTOR: if (mem_ready) state <= IFP_REFILL;
				IFP_REFILL: if (refill_done) state <= IFP_IDLE;
				default: state <= IFP_IDLE;
			endcase
		end
	end

	// capture of the frame contents; the status copy is taken before mode changes
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			saved_sr <= 16'h0000;
			saved_pc <= 32'h0000_0000;
			saved_ea <= 32'h0000_0000;
			saved_fpc <= 32'h0000_0000;
		end else if (state == IFP_DRAIN && pipe_idle) begin
			saved_sr <= status_word_in;
			saved_pc <= next_pc_in;
			saved_ea <= fp_ea_none ? IFP_EA_NONE : fp_ea;
			saved_fpc <= fp_instr_pc;
		end
	end

	// status update: supervisor set, both trace bits cleared, written during the first push cycle
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			status_word_out <= IFP_SR_RESET;
			status_word_we <= 1'b0;
		end else begin
			status_word_we <= (state == IFP_ENTER);
			if (state == IFP_ENTER) begin
				status_word_out <= saved_sr;
				status_word_out[IFP_SR_S] <= 1'b1;
				status_word_out[IFP_SR_T1] <= 1'b0;
				status_word_out[IFP_SR_T0] <= 1'b0;
			end
		end
	end

	// memory strobes are combinational handshakes; data is derived from registers, the address also from the vbr and stack_ptr inputs
	assign mem_wr = (state == IFP_PUSH);
	assign mem_rd = (state == IFP_VECTOR);
	assign mem_wdata = frame_word;
	assign mem_addr = (state == IFP_VECTOR) ? vbr + {20'h0, IFP_VECTOR_OFFSET}
		: stack_ptr - 32'h10 + {28'h0, word_idx, 1'b0};
	assign refill_req = (state == IFP_REFILL);
	assign new_sp = stack_ptr - 32'h10; // eight words below the old pointer

	// handler address latched from the vector table
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			handler_pc <= 32'h0000_0000;
			rd_idx <= 3'h0;
		end else begin
			rd_idx <= word_idx;
			if (state == IFP_VECTOR && mem_ready) handler_pc <= mem_rdata;
		end
	end

	// handler start pulse
	always_ff @(posedge clk_sys) begin
		if (!rstn) trap_taken <= 1'b0;
		else trap_taken <= (state == IFP_REFILL && refill_done);
	end

	// checks
	// the sequencer must not leave the drain state while older work is still in flight
	a_no_enter_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state == IFP_DRAIN && !pipe_idle) |=> state == IFP_DRAIN) else $error("entered before drain");
	// the new status word always has supervisor set and both trace bits cleared
	a_trace_cleared: assert property (@(posedge clk_sys) disable iff (!rstn)
		status_word_we |-> !status_word_out[IFP_SR_T1] && !status_word_out[IFP_SR_T0] && status_word_out[IFP_SR_S])
		else $error("trace or supervisor wrong");
	// word three of the frame carries the format code
	a_format_word: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mem_wr && word_idx == 3'h3) |-> mem_wdata[15:12] == 4'h4) else $error("bad format code");
	// immediate and register modes store a zero address
	a_ea_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state == IFP_DRAIN && pipe_idle && fp_ea_none) |=> saved_ea == 32'h0) else $error("ea not zero");
	// the vector fetch reads entry eleven of the table
	a_vector_addr: assert property (@(posedge clk_sys) disable iff (!rstn)
		mem_rd |-> mem_addr == vbr + 32'h2c) else $error("wrong vector");
	// no pin can move the bus away from the plain synchronous mode
	a_bus_fixed: assert property (@(posedge clk_sys) disable iff (!rstn)
		bus_mode == 2'h0 && impedance_small && !fp_exec_enable) else $error("config changed");
	// the old latch pin only steers the scan chain
	a_scan_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
		scan_chain_sel == scan_select_pin) else $error("scan select");
	// the new status word keeps the low bits of the copy taken before the mode change
	a_sr_saved: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state == IFP_DRAIN && pipe_idle) |=> ##1 status_word_we
		&& status_word_out[12:0] == $past(status_word_in[12:0], 2)) else $error("status copy lost");
	// the registered readback returns the word written two edges before
	a_frame_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
		(state == IFP_PUSH && mem_ready) |=> ##1 frame_rd == $past(frame_word, 2))
		else $error("frame readback wrong");
	// a stalled write keeps its word until the memory takes it
	a_push_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mem_wr && !mem_ready) |=> mem_wr && $stable(word_idx)) else $error("stalled word moved");
	// accepted words advance one at a time, so all eight go out in order
	a_push_step: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mem_wr && mem_ready && word_idx != IFP_FRAME_LAST) |=> mem_wr && word_idx == $past(word_idx) + 3'h1)
		else $error("frame word skipped");
	// the vector fetch follows the last frame word at once
	a_vector_next: assert property (@(posedge clk_sys) disable iff (!rstn)
		(mem_wr && mem_ready && word_idx == IFP_FRAME_LAST) |=> mem_rd) else $error("no vector fetch");
	// the handler starts only after a finished refill, back in idle
	a_taken_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
		trap_taken |-> $past(refill_req && refill_done) && state == IFP_IDLE) else $error("early handler start");
	// main scenarios: a full trap, a zero address, stalls on the push and on the vector fetch
	c_trap_done: cover property (@(posedge clk_sys) disable iff (!rstn) trap_taken);
	c_vector_stall: cover property (@(posedge clk_sys) disable iff (!rstn) mem_rd && !mem_ready);
	c_ea_none: cover property (@(posedge clk_sys) disable iff (!rstn) state == IFP_DRAIN && pipe_idle && fp_ea_none);
	c_push_stall: cover property (@(posedge clk_sys) disable iff (!rstn) mem_wr && !mem_ready);
endmodule : ifp_trap_unit

// [tb/tb.sv]
// testbench for the float trap sequencer: random traps with memory and refill stalls
// assumes ifp_pkg and ifp_trap_unit are compiled first; the frame memory is only checked by the unit's readback assertion
`timescale 1ns/1ps
module tb;
	import ifp_pkg::*;
	logic clk_sys, rstn, fp_instr_valid, fp_ea_none, pipe_idle, mem_ready, refill_done; // driven inputs
	logic cache_disable_pin, scan_select_pin; // pins that must not steer bus configuration; scan select only picks the scan chain
	logic [2:0] interrupt_priority_pins; // random noise, no effect expected
	logic [15:0] status_word_in, status_word_out, mem_wdata;
	logic [31:0] fp_instr_pc, next_pc_in, fp_ea, vbr, stack_ptr, mem_rdata, mem_addr, handler_pc, new_sp;
	logic [31:0] rs, rq, hp_exp; // two random streams and the expected handler address
	logic in_refill; // refill request is expected to stand
	logic [4:0] cfg_seen; // fixed configuration outputs and scan_chain_sel gathered for one compare
	logic fp_exec_enable, trap_taken, status_word_we, mem_wr, mem_rd, refill_req, impedance_small, scan_chain_sel;
	logic [1:0] bus_mode;
	int error_cnt, n_checks, nw, nv, nt; // nv counts vector fetches of the current trap
	assign cfg_seen = {fp_exec_enable, bus_mode, impedance_small, scan_chain_sel};
	ifp_trap_unit i_ifp_trap_unit (.clk_sys(clk_sys), .rstn(rstn), .fp_instr_valid(fp_instr_valid),
		.fp_instr_pc(fp_instr_pc), .next_pc_in(next_pc_in), .fp_ea(fp_ea), .fp_ea_none(fp_ea_none),
		.pipe_idle(pipe_idle), .status_word_in(status_word_in), .vbr(vbr), .stack_ptr(stack_ptr),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata), .refill_done(refill_done),
		.cache_disable_pin(cache_disable_pin), .interrupt_priority_pins(interrupt_priority_pins),
		.scan_select_pin(scan_select_pin), .fp_exec_enable(fp_exec_enable), .trap_taken(trap_taken),
		.status_word_out(status_word_out), .status_word_we(status_word_we), .mem_wr(mem_wr), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .handler_pc(handler_pc), .refill_req(refill_req),
		.new_sp(new_sp), .bus_mode(bus_mode), .impedance_small(impedance_small), .scan_chain_sel(scan_chain_sel));
	// shift register for repeatable random values
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// expected frame word i, worked out from the captured trap inputs
	function automatic logic [15:0] frame_word(input int i);
		logic [31:0] ea;
		logic [15:0] w [8];
		ea = fp_ea_none ? 32'h0 : fp_ea;
		w = '{status_word_in, next_pc_in[31:16], next_pc_in[15:0], 16'h402c, ea[31:16], ea[15:0],
			fp_instr_pc[31:16], fp_instr_pc[15:0]};
		return w[i];
	endfunction : frame_word
	// expected status word after entry: supervisor set, both trace bits cleared
	function automatic logic [31:0] exp_sr(input logic [15:0] s);
		return {16'h0, (s & 16'h3fff) | 16'h2000};
	endfunction : exp_sr
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task complete_run();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	// one float trap: hold the request, keep the pipeline busy for drain cycles, then follow the frame
	task trap(input logic [15:0] sw, input logic none, input int drain);
		int k;
		rs = lfsr(rs);
		fp_instr_pc = {rs[31:1], 1'b0};
		next_pc_in = fp_instr_pc + 32'h4;
		rs = lfsr(rs);
		fp_ea = rs;
		vbr = {rs[15:0], rs[31:22], 6'h0};
		stack_ptr = {rs[30:0], 1'b0};
		status_word_in = sw;
		fp_ea_none = none;
		nw = 0;
		nv = 0;
		fp_instr_valid = 1'b1;
		pipe_idle = 1'b0;
		repeat (drain) begin
			@(posedge clk_sys);
			#1;
			chk("early push", 32'h0, {31'h0, mem_wr});
		end
		pipe_idle = 1'b1;
		for (k = 0; k < 300 && trap_taken !== 1'b1; k++) begin
			@(posedge clk_sys);
			#1;
		end
		if (k == 300) begin
			chk("trap timeout", 32'h0, 32'h1);
			complete_run();
		end
		fp_instr_valid = 1'b0;
		chk("frame words", 32'h8, 32'(nw));
		chk("vector reads", 32'h1, 32'(nv));
		chk("new sp", stack_ptr - 32'h10, new_sp);
		chk("handler", hp_exp, handler_pc);
		@(posedge clk_sys);
		#1;
		chk("taken pulse", 32'h0, {31'h0, trap_taken});
	endtask : trap
	// far side: random memory stalls, refill delay and noise on the ignored pins, also during reset
	always @(posedge clk_sys) begin
		#1;
		rq = lfsr(rq);
		mem_ready = rq[0] | rq[1];
		refill_done = rq[2];
		mem_rdata = rq;
		cache_disable_pin = rq[3];
		interrupt_priority_pins = rq[6:4];
		scan_select_pin = rq[7];
	end
	// monitor: sampled at the falling edge, where outputs and far-side inputs have settled for the next edge
	always @(negedge clk_sys) begin
		if (rstn) begin
			chk("refill req", {31'h0, in_refill}, {31'h0, refill_req});
			chk("config", {31'h1, scan_select_pin}, {27'h0, cfg_seen});
			if (status_word_we) chk("status", exp_sr(status_word_in), {16'h0, status_word_out});
			if (mem_wr && mem_ready) begin
				chk("frame addr", stack_ptr - 32'h10 + 32'(2 * nw), mem_addr);
				chk("frame word", {16'h0, frame_word(nw)}, {16'h0, mem_wdata});
				nw++;
			end
			// the refill request must stand from the vector fetch until refill is done
			if (mem_rd && mem_ready) begin
				chk("vector addr", vbr + 32'h2c, mem_addr);
				hp_exp = mem_rdata;
				nv++;
				in_refill = 1'b1;
			end else if (refill_req && refill_done) begin
				in_refill = 1'b0;
			end
		end
	end
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		{rstn, fp_instr_valid, fp_ea_none, mem_ready, refill_done, cache_disable_pin, scan_select_pin} = '0;
		{interrupt_priority_pins, status_word_in, fp_instr_pc, next_pc_in, fp_ea, vbr, stack_ptr, mem_rdata} = '0;
		pipe_idle = 1'b1;
		rs = 32'h55ce;
		rq = 32'h55ce;
		hp_exp = '0;
		{error_cnt, n_checks, nw, nv} = '0;
		in_refill = 1'b0;
		repeat (8) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		chk("reset status", 32'h2700, {16'h0, status_word_out});
		chk("reset idle", 32'h0, {27'h0, trap_taken, mem_wr, mem_rd, refill_req, status_word_we});
		chk("reset handler", 32'h0, handler_pc);
		trap(16'hffff, 1'b1, 0);
		trap(16'h0000, 1'b0, 5);
		for (nt = 0; nt < 6; nt++) begin
			rs = lfsr(rs);
			trap(rs[15:0], rs[16], int'(rs[19:17]));
		end
		complete_run();
	end
endmodule : tb
